// file: oms_selector.sv
// Operation mode selector top
// What this block does
// - Switch inputs reach network mode only for 0,2,6,7, stopped unless 6
// - Setting 6 allows changes while running
// - Net/panel input on gives panel, off network
// - Startup 10: settings 1,2,3/4 fix mode
// - Net/panel input alone never selects external
// - Net/external input on overrides panel request to network
// - Network request becomes panel if panel/external off, external if on under setting 7
// - Setting 7: interlock off forces external
// - Setting 7 external mode with interlock on stops output
// - Net/external input on gives network, off external
// - Startup 0, setting 2: network or external only
// - External request becomes panel only if panel/external is assigned and off
// - Priority: setting, interlock, net/ext, net/panel (startup 10 only), panel/ext; under setting 2 startup 10 comes first
// - Panel/external input picks external or panel
`include "oms_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module oms_selector (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [3:0] mode_select_param,
   input  wire logic [3:0] startup_mode_param,
   input  wire logic       net_panel_assigned,
   input  wire logic       net_external_assigned,
   input  wire logic       panel_external_assigned,
   input  wire logic       net_panel_switch_in,
   input  wire logic       net_external_switch_in,
   input  wire logic       panel_external_switch_in,
   input  wire logic       panel_interlock_in,
   input  wire logic       motor_stopped_in,
   input  wire logic       start_cmd_in,
   output var  logic [3:0] op_mode,
   output var  logic       panel_mode,
   output var  logic       output_stop,
   output var  logic       change_pending
);
   logic       rst_meta;
   logic       rst_n;
   logic [3:0] mode;
   logic [3:0] next_mode;
   logic [3:0] want;
   logic       next_stop;
   logic       next_pending;
   logic       next_panel;
   logic       sel_free;
   logic       interlock_on;
   oms_sync_if sync ();

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   oms_inputs u_in (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .net_panel_switch_in      (net_panel_switch_in),
      .net_external_switch_in   (net_external_switch_in),
      .panel_external_switch_in (panel_external_switch_in),
      .panel_interlock_in       (panel_interlock_in),
      .motor_stopped_in         (motor_stopped_in),
      .start_cmd_in             (start_cmd_in),
      .sync                     (sync)
   );

   assign sel_free = (mode_select_param == `OMS_SEL_FREE) || (mode_select_param == `OMS_SEL_RUNSW)
                     || (mode_select_param == `OMS_SEL_ILOCK);
   assign interlock_on = (mode_select_param != `OMS_SEL_ILOCK) || sync.interlock;

   // Requested mode, resolved in priority order
   always_comb begin
      want = mode;
      case (mode_select_param)
         `OMS_SEL_PANEL: want = oms_pkg::OMS_PANEL;
         `OMS_SEL_COMB_A,
         `OMS_SEL_COMB_B: want = oms_pkg::OMS_COMB;
         `OMS_SEL_EXT: begin
            if (startup_mode_param == `OMS_START_PANEL)
               want = oms_pkg::OMS_NET;
            else if (net_external_assigned)
               want = sync.net_ext ? oms_pkg::OMS_NET : oms_pkg::OMS_EXT;
            else
               want = oms_pkg::OMS_EXT;
         end
         `OMS_SEL_FREE,
         `OMS_SEL_RUNSW,
         `OMS_SEL_ILOCK: begin
            if (!interlock_on)
               want = oms_pkg::OMS_EXT;
            else if (net_external_assigned && sync.net_ext)
               want = oms_pkg::OMS_NET;
            else if (net_panel_assigned && startup_mode_param == `OMS_START_PANEL) begin
               if (sync.net_panel)
                  want = oms_pkg::OMS_PANEL;
               else if (panel_external_assigned && !sync.panel_ext)
                  want = oms_pkg::OMS_PANEL;
               else if (panel_external_assigned && sync.panel_ext
                        && mode_select_param == `OMS_SEL_ILOCK)
                  want = oms_pkg::OMS_EXT;
               else
                  want = oms_pkg::OMS_NET;
            end else if (net_external_assigned) begin
               if (panel_external_assigned && !sync.panel_ext)
                  want = oms_pkg::OMS_PANEL;
               else
                  want = oms_pkg::OMS_EXT;
            end else if (panel_external_assigned)
               want = sync.panel_ext ? oms_pkg::OMS_EXT : oms_pkg::OMS_PANEL;
         end
         default: want = mode;
      endcase
   end

   // Change only while stopped unless setting 6; forced external is immediate
   always_comb begin
      next_mode = mode;
      next_pending = 1'b0;
      if (want != mode) begin
         if (sync.stopped || mode_select_param == `OMS_SEL_RUNSW || !interlock_on)
            next_mode = want;
         else
            next_pending = 1'b1;
      end
      next_panel = (next_mode == oms_pkg::OMS_PANEL);
      next_stop = (mode_select_param == `OMS_SEL_ILOCK) && sync.interlock
                  && (next_mode == oms_pkg::OMS_EXT);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode           <= `OMS_MODE_RESET;
         op_mode        <= `OMS_MODE_RESET;
         panel_mode     <= 1'b0;
         output_stop    <= 1'b0;
         change_pending <= 1'b0;
      end else begin
         mode           <= next_mode;
         op_mode        <= next_mode;
         panel_mode     <= next_panel;
         output_stop    <= next_stop;
         change_pending <= next_pending;
      end
   end

   a_hold_running: assert property (@(posedge clk) disable iff (!rst_n)
      (!sync.stopped && mode_select_param == `OMS_SEL_FREE && interlock_on) |=> $stable(mode))
      else $error("mode changed while running");
   a_force_ext: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_select_param == `OMS_SEL_ILOCK && !sync.interlock) |=> (mode == oms_pkg::OMS_EXT))
      else $error("interlock off did not force external");
   a_fixed_panel: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_select_param == `OMS_SEL_PANEL && sync.stopped) |=> (mode == oms_pkg::OMS_PANEL))
      else $error("setting 1 not panel");
   a_stop_out: assert property (@(posedge clk) disable iff (!rst_n)
      output_stop |-> (op_mode == oms_pkg::OMS_EXT))
      else $error("output stop outside external");
   a_no_panel_two: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_select_param == `OMS_SEL_EXT && $past(mode_select_param) == `OMS_SEL_EXT
       && startup_mode_param == `OMS_START_EXT && $past(mode) != oms_pkg::OMS_PANEL)
      |-> (mode != oms_pkg::OMS_PANEL))
      else $error("panel reached under setting 2");
   a_run_switch: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_select_param == `OMS_SEL_RUNSW && net_external_assigned && sync.net_ext)
      |=> (mode == oms_pkg::OMS_NET))
      else $error("setting 6 did not switch while running");
   a_net_prio: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && net_external_assigned && sync.net_ext)
      |=> (mode == oms_pkg::OMS_NET))
      else $error("net/external did not win");
   a_panel_on: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && !(net_external_assigned && sync.net_ext)
       && net_panel_assigned && startup_mode_param == `OMS_START_PANEL && sync.net_panel)
      |=> (mode == oms_pkg::OMS_PANEL))
      else $error("net/panel on did not give panel");

   // A change asked for while running, not under setting 6
   sequence s_defer;
      !sync.stopped && (mode_select_param != `OMS_SEL_RUNSW) && interlock_on && (want != mode);
   endsequence

   // The same change once the stop condition holds a cycle later
   sequence s_defer_release;
      s_defer ##1 sync.stopped;
   endsequence

   a_pending_set: assert property (@(posedge clk) disable iff (!rst_n)
      s_defer |=> (change_pending && $stable(mode)))
      else $error("running change was not deferred");
   a_defer_release: assert property (@(posedge clk) disable iff (!rst_n)
      s_defer_release |=> (!change_pending && (mode == $past(want))))
      else $error("deferred change not applied at stop");
   a_pending_cause: assert property (@(posedge clk) disable iff (!rst_n)
      change_pending |-> !$past(sync.stopped))
      else $error("pending flag raised while stopped");
   a_release_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (sync.stopped && (want != mode)) |=> (mode == $past(want)))
      else $error("change not taken while stopped");
   a_run_change: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_RUNSW) && (want != mode))
      |=> ((mode == $past(want)) && !change_pending))
      else $error("setting 6 held a change back");
   a_hold_ext_set: assert property (@(posedge clk) disable iff (!rst_n)
      (!sync.stopped && (mode_select_param == `OMS_SEL_EXT)) |=> $stable(mode))
      else $error("setting 2 changed mode while running");
   a_hold_ilock: assert property (@(posedge clk) disable iff (!rst_n)
      (!sync.stopped && (mode_select_param == `OMS_SEL_ILOCK) && sync.interlock)
      |=> $stable(mode))
      else $error("setting 7 changed mode while running");

   // Interlock and output stop
   a_ilock_running: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_ILOCK) && !sync.interlock && !sync.stopped)
      |=> ((mode == oms_pkg::OMS_EXT) && !change_pending))
      else $error("interlock off waited for stop");
   a_ilock_stop: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_ILOCK) && sync.interlock && (next_mode == oms_pkg::OMS_EXT))
      |=> output_stop)
      else $error("external under setting 7 kept output running");
   a_stop_cause: assert property (@(posedge clk) disable iff (!rst_n)
      output_stop |-> (($past(mode_select_param) == `OMS_SEL_ILOCK) && $past(sync.interlock)))
      else $error("output stopped without setting 7 and interlock");

   // Paths through the net/panel switch
   a_np_off_net: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && !(net_external_assigned && sync.net_ext)
       && net_panel_assigned && (startup_mode_param == `OMS_START_PANEL) && !sync.net_panel
       && !panel_external_assigned)
      |=> (mode == oms_pkg::OMS_NET))
      else $error("net/panel off did not give network");
   a_np_never_ext: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && (mode_select_param != `OMS_SEL_ILOCK) && sync.stopped
       && !(net_external_assigned && sync.net_ext) && net_panel_assigned
       && (startup_mode_param == `OMS_START_PANEL))
      |=> (mode != oms_pkg::OMS_EXT))
      else $error("net/panel path reached external");
   a_np_panel_fall: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && !(net_external_assigned && sync.net_ext)
       && net_panel_assigned && (startup_mode_param == `OMS_START_PANEL) && !sync.net_panel
       && panel_external_assigned && !sync.panel_ext)
      |=> (mode == oms_pkg::OMS_PANEL))
      else $error("network request with panel/external off not panel");
   a_np_ilock_ext: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_ILOCK) && sync.interlock && sync.stopped
       && !(net_external_assigned && sync.net_ext) && net_panel_assigned
       && (startup_mode_param == `OMS_START_PANEL) && !sync.net_panel
       && panel_external_assigned && sync.panel_ext)
      |=> (mode == oms_pkg::OMS_EXT))
      else $error("setting 7 network request with panel/external on not external");

   // Paths through the net/external switch
   a_ne_panel: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && net_external_assigned && !sync.net_ext
       && !(net_panel_assigned && (startup_mode_param == `OMS_START_PANEL))
       && panel_external_assigned && !sync.panel_ext)
      |=> (mode == oms_pkg::OMS_PANEL))
      else $error("external request with panel/external off not panel");
   a_ne_off_ext: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && net_external_assigned && !sync.net_ext
       && !(net_panel_assigned && (startup_mode_param == `OMS_START_PANEL))
       && !panel_external_assigned)
      |=> (mode == oms_pkg::OMS_EXT))
      else $error("net/external off did not give external");
   a_two_net: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_EXT) && (startup_mode_param != `OMS_START_PANEL)
       && net_external_assigned && sync.net_ext && sync.stopped)
      |=> (mode == oms_pkg::OMS_NET))
      else $error("setting 2 net/external on not network");
   a_two_ext: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_EXT) && (startup_mode_param != `OMS_START_PANEL)
       && net_external_assigned && !sync.net_ext && sync.stopped)
      |=> (mode == oms_pkg::OMS_EXT))
      else $error("setting 2 net/external off not external");

   // Paths through the panel/external switch
   a_pe_ext: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && !net_external_assigned
       && !(net_panel_assigned && (startup_mode_param == `OMS_START_PANEL))
       && panel_external_assigned && sync.panel_ext)
      |=> (mode == oms_pkg::OMS_EXT))
      else $error("panel/external on did not give external");
   a_pe_panel: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_free && interlock_on && sync.stopped && !net_external_assigned
       && !(net_panel_assigned && (startup_mode_param == `OMS_START_PANEL))
       && panel_external_assigned && !sync.panel_ext)
      |=> (mode == oms_pkg::OMS_PANEL))
      else $error("panel/external off did not give panel");

   // Fixed settings and output consistency
   a_fixed_comb: assert property (@(posedge clk) disable iff (!rst_n)
      (((mode_select_param == `OMS_SEL_COMB_A) || (mode_select_param == `OMS_SEL_COMB_B)) && sync.stopped)
      |=> (mode == oms_pkg::OMS_COMB))
      else $error("settings 3 and 4 not combined");
   a_fixed_net: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_select_param == `OMS_SEL_EXT) && (startup_mode_param == `OMS_START_PANEL) && sync.stopped)
      |=> (mode == oms_pkg::OMS_NET))
      else $error("setting 2 with startup 10 not network");
   a_panel_flag: assert property (@(posedge clk) disable iff (!rst_n)
      panel_mode == (op_mode == oms_pkg::OMS_PANEL))
      else $error("panel flag disagrees with mode");
   a_mode_out: assert property (@(posedge clk) disable iff (!rst_n)
      op_mode == mode)
      else $error("mode output differs from held mode");
   a_mode_onehot: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot(mode))
      else $error("mode is not a single selection");
endmodule // oms_selector
`default_nettype wire

// file: oms_defs.svh
// Constants for the operation mode selector
`ifndef OMS_DEFS_SVH
`define OMS_DEFS_SVH
`define OMS_SEL_FREE    4'h0
`define OMS_SEL_PANEL   4'h1
`define OMS_SEL_EXT     4'h2
`define OMS_SEL_COMB_A  4'h3
`define OMS_SEL_COMB_B  4'h4
`define OMS_SEL_RUNSW   4'h6
`define OMS_SEL_ILOCK   4'h7
`define OMS_START_EXT   4'h0
`define OMS_START_NET   4'h1
`define OMS_START_PANEL 4'ha
`define OMS_MODE_RESET  4'h2
`endif

// file: oms_pkg.sv
// Types for the operation mode selector
package oms_pkg;
   typedef enum logic [3:0] {
      OMS_PANEL = 4'h1,
      OMS_EXT   = 4'h2,
      OMS_NET   = 4'h4,
      OMS_COMB  = 4'h8
   } oms_mode_t;
endpackage

// file: oms_sync_if.sv
// Synchronised switch inputs shared between modules
`timescale 1ns/1ns
`default_nettype none
interface oms_sync_if;
   logic       net_panel;
   logic       net_ext;
   logic       panel_ext;
   logic       interlock;
   logic       stopped;
   modport src (output net_panel, net_ext, panel_ext, interlock, stopped);
   modport dst (input  net_panel, net_ext, panel_ext, interlock, stopped);
endinterface
`default_nettype wire

// file: oms_sync2.sv
// Two flip-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module oms_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;
   always_comb begin
      next_meta = d;
      next_q    = meta;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule // oms_sync2
`default_nettype wire

// file: oms_inputs.sv
// Synchronises the terminal inputs onto the block clock
`timescale 1ns/1ns
`default_nettype none
module oms_inputs (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic net_panel_switch_in,
   input  wire logic net_external_switch_in,
   input  wire logic panel_external_switch_in,
   input  wire logic panel_interlock_in,
   input  wire logic motor_stopped_in,
   input  wire logic start_cmd_in,
   oms_sync_if.src   sync
);
   logic [5:0] raw;
   logic [5:0] syn;
   assign raw = {net_panel_switch_in, net_external_switch_in, panel_external_switch_in,
                 panel_interlock_in, motor_stopped_in, start_cmd_in};
   oms_sync2 #(.W(6)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (raw),
      .q     (syn)
   );
   // Stopped means motor at rest or no start command
   assign sync.net_panel = syn[5];
   assign sync.net_ext   = syn[4];
   assign sync.panel_ext = syn[3];
   assign sync.interlock = syn[2];
   assign sync.stopped   = syn[1] | ~syn[0];
endmodule // oms_inputs
`default_nettype wire

// file: oms_far_end.sv
// Far side model: operator settings, input terminals and motor state
`timescale 1ns/1ns
`default_nettype none
module oms_far_end (
   input  wire logic       clk,
   output var  logic [3:0] msel,
   output var  logic [3:0] smode,
   output var  logic [2:0] asg,
   output var  logic [3:0] sw,
   output var  logic       stopped,
   output var  logic       start
);
   initial begin
      msel = 4'h0;
      smode = 4'h0;
      asg = 3'h0;
      sw = 4'h0;
      stopped = 1'b1;
      start = 1'b0;
   end
   // Everything the far side owns changes only at the falling edge
   task automatic apply(input logic [3:0] m, input logic [3:0] s, input logic [2:0] a, input logic [3:0] w,
                        input logic run);
      @(negedge clk);
      msel = m;
      smode = s;
      asg = a;
      sw = w;
      stopped = !run;
      start = run;
   endtask
endmodule // oms_far_end
`default_nettype wire

// file: oms_selector_tb.sv
// Self-checking bench for the operation mode selector
`timescale 1ns/1ns
`default_nettype none
module oms_selector_tb;
   typedef struct packed {logic [3:0] m; logic [3:0] s; logic [2:0] a; logic [3:0] w; logic [3:0] x; logic o;} oms_row_t;
   localparam logic [3:0] MP = oms_pkg::OMS_PANEL;
   localparam logic [3:0] ME = oms_pkg::OMS_EXT;
   localparam logic [3:0] MN = oms_pkg::OMS_NET;
   localparam logic [3:0] MC = oms_pkg::OMS_COMB;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [3:0] msel, smode, sw, op_mode;
   logic [2:0] asg;
   logic       stopped, start, panel_mode, output_stop, change_pending;
   int         err_count = 0;
   int         comparisons = 0;
   int         cycles = 0;
   // Switch bits: net/panel, net/ext, panel/ext, interlock
   oms_row_t   rows [0:14] = '{
      '{4'h0, 4'h0, 3'h2, 4'h4, MN, 1'b0},
      '{4'h0, 4'h0, 3'h3, 4'h0, MP, 1'b0},
      '{4'h0, 4'h0, 3'h3, 4'h2, ME, 1'b0},
      '{4'h2, 4'h0, 3'h3, 4'h0, ME, 1'b0},
      '{4'h2, 4'h0, 3'h3, 4'h4, MN, 1'b0},
      '{4'h0, 4'ha, 3'h4, 4'h8, MP, 1'b0},
      '{4'h0, 4'ha, 3'h4, 4'h0, MN, 1'b0},
      '{4'h6, 4'ha, 3'h6, 4'hc, MN, 1'b0},
      '{4'h1, 4'ha, 3'h4, 4'h0, MP, 1'b0},
      '{4'h2, 4'ha, 3'h4, 4'h8, MN, 1'b0},
      '{4'h3, 4'ha, 3'h4, 4'h8, MC, 1'b0},
      '{4'h7, 4'h0, 3'h3, 4'h4, ME, 1'b0},
      '{4'h7, 4'h0, 3'h3, 4'h3, ME, 1'b1},
      '{4'h7, 4'ha, 3'h5, 4'h3, ME, 1'b1},
      '{4'h7, 4'ha, 3'h5, 4'h1, MP, 1'b0}};

   oms_far_end far_u (.clk(clk), .msel(msel), .smode(smode), .asg(asg), .sw(sw), .stopped(stopped), .start(start));
   oms_selector dut_u (
      .clk(clk), .arst_n(arst_n), .mode_select_param(msel), .startup_mode_param(smode),
      .net_panel_assigned(asg[2]), .net_external_assigned(asg[1]), .panel_external_assigned(asg[0]),
      .net_panel_switch_in(sw[3]), .net_external_switch_in(sw[2]), .panel_external_switch_in(sw[1]),
      .panel_interlock_in(sw[0]), .motor_stopped_in(stopped), .start_cmd_in(start),
      .op_mode(op_mode), .panel_mode(panel_mode), .output_stop(output_stop), .change_pending(change_pending));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Three edges from pin to output, sampled at the fourth falling edge
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      repeat (16) @(negedge clk);
      chk(op_mode, ME);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         far_u.apply(rows[i].m, rows[i].s, rows[i].a, rows[i].w, 1'b0);
         settle();
         chk(op_mode, rows[i].x);
         chk({3'h0, panel_mode}, {3'h0, rows[i].x == MP});
         chk({3'h0, output_stop}, {3'h0, rows[i].o});
      end
      $display("table test done");
      arst_n = 1'b0;
      @(negedge clk);
      chk(op_mode, ME);
      chk({3'h0, output_stop}, 4'h0);
      arst_n = 1'b1;
      $display("mid-run reset test done");
      far_u.apply(4'h0, 4'h0, 3'h3, 4'h0, 1'b0);
      settle();
      chk(op_mode, MP);
      far_u.apply(4'h0, 4'h0, 3'h3, 4'h4, 1'b1);
      settle();
      chk(op_mode, MP);
      chk({3'h0, change_pending}, 4'h1);
      far_u.apply(4'h0, 4'h0, 3'h3, 4'h4, 1'b0);
      settle();
      chk(op_mode, MN);
      chk({3'h0, change_pending}, 4'h0);
      $display("deferred change test done");
      far_u.apply(4'h6, 4'h0, 3'h3, 4'h2, 1'b1);
      settle();
      chk(op_mode, ME);
      chk({3'h0, change_pending}, 4'h0);
      $display("running switch test done");
      far_u.apply(4'h7, 4'h0, 3'h3, 4'h5, 1'b0);
      settle();
      chk(op_mode, MN);
      far_u.apply(4'h7, 4'h0, 3'h3, 4'h4, 1'b1);
      settle();
      chk(op_mode, ME);
      $display("interlock test done");
      end_sim();
   end
endmodule // oms_selector_tb
`default_nettype wire
